//--- logic/pmw_ctrl.v
// Purpose: power-mode sequencer with external wake pin selection
// Assumes: cpu reports decoded opcodes; one clock, sync reset
// Notes:   clock gates are enables for downstream clock gating cells
`timescale 1ns/10ps
`include "pmw_map.vh"

module pmw_ctrl (
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite slave
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    // cpu side
    input  wire        opcode_valid,
    input  wire [7:0]  opcode,
    input  wire        wfi_decoded,
    input  wire        irq_pending,
    input  wire        irq_halt_capable,
    input  wire        irq_ahalt_capable,
    input  wire        wdg_halt_option,
    input  wire        stab_long_cfg,
    input  wire [7:0]  port_a_pins,
    input  wire [7:0]  port_b_pins,
    output reg         cpu_clk_en,
    output reg         periph_clk_en,
    output reg         osc_run,
    output reg         timer_clk_en,
    output reg         clk_div_tick,
    output reg         clear_imask,
    output reg         wdg_reset_req,
    output reg         fetch_reset_vec,
    output reg         service_irq,
    output reg  [3:0]  ext_irq_lines,
    output reg  [2:0]  mode_out
);

// ==========================================================
// axi4-lite slave
reg  [7:0]  pinsel_r;
reg  [6:0]  ctrl_r;
reg         aw_hold_r;
reg         w_hold_r;
reg  [3:0]  awaddr_r;
reg  [31:0] wdata_r;
reg  [3:0]  wstrb_r;
reg         bvalid_r;
reg         bslverr_r;
reg         rvalid_r;
reg         rslverr_r;
reg  [31:0] rdata_r;
reg  [2:0]  mode_r;
reg         was_ahalt_r;
reg         stab_long_r;
reg  [12:0] stab_cnt_r;
reg  [4:0]  div_cnt_r;
reg  [7:0]  pa_sync1_r;
reg  [7:0]  pa_sync2_r;
reg  [7:0]  pb_sync1_r;
reg  [7:0]  pb_sync2_r;
reg         halt_seen_r;
reg         reset_wake_r;

wire        do_write;
wire        wr_ok;
wire        rd_ok;
wire [31:0] status_word;

assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
assign s_axi_bvalid  = bvalid_r;
assign s_axi_bresp   = bslverr_r ? 2'h2 : 2'h0;
assign s_axi_arready = ~rvalid_r;
assign s_axi_rvalid  = rvalid_r;
assign s_axi_rdata   = rdata_r;
assign s_axi_rresp   = rslverr_r ? 2'h2 : 2'h0;

// a write commits once address and data are both held
assign do_write = aw_hold_r & w_hold_r & ~bvalid_r;
assign wr_ok    = (awaddr_r == `PMW_OFF_PINSEL) |
                  (awaddr_r == `PMW_OFF_CTRL);
assign rd_ok    = (s_axi_araddr == `PMW_OFF_PINSEL) |
                  (s_axi_araddr == `PMW_OFF_CTRL) |
                  (s_axi_araddr == `PMW_OFF_STATUS);
assign status_word = {24'h000000, stab_long_r, was_ahalt_r,
                      1'b0, 2'h0, mode_r};

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        awaddr_r  <= 4'h0;
        wdata_r   <= 32'h00000000;
        wstrb_r   <= 4'h0;
        bvalid_r  <= 1'b0;
        bslverr_r <= 1'b0;
        rvalid_r  <= 1'b0;
        rslverr_r <= 1'b0;
        rdata_r   <= 32'h00000000;
        pinsel_r  <= `PMW_PINSEL_RST;
        ctrl_r    <= `PMW_CTRL_RST;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= {s_axi_awaddr[3:2], 2'h0};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
        end
        if (do_write) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bslverr_r <= ~wr_ok;
            if (wstrb_r[0] && awaddr_r == `PMW_OFF_PINSEL)
                pinsel_r <= wdata_r[7:0];
            if (wstrb_r[0] && awaddr_r == `PMW_OFF_CTRL)
                ctrl_r <= wdata_r[6:0];
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
        // read data is registered; rvalid follows the address by a cycle
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r  <= 1'b1;
            rslverr_r <= ~rd_ok;
            case (s_axi_araddr[3:2])
                2'h0:    rdata_r <= {24'h000000, pinsel_r};
                2'h1:    rdata_r <= {25'h0000000, ctrl_r};
                2'h2:    rdata_r <= status_word;
                default: rdata_r <= 32'h00000000;
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
end

// ==========================================================
// external interrupt pin routing
// pins pass two flip-flops before any decode
always @(posedge aclk) begin
    if (!aresetn) begin
        pa_sync1_r <= 8'h00;
        pa_sync2_r <= 8'h00;
        pb_sync1_r <= 8'h00;
        pb_sync2_r <= 8'h00;
    end else begin
        pa_sync1_r <= port_a_pins;
        pa_sync2_r <= pa_sync1_r;
        pb_sync1_r <= port_b_pins;
        pb_sync2_r <= pb_sync1_r;
    end
end

reg         line2_raw;
reg         line3_raw;
wire        in_halt;

assign in_halt = (mode_r == `PMW_MODE_HALT) |
                 (mode_r == `PMW_MODE_AWU);

always @* begin
    case (pinsel_r[7:6])
        2'h0:    line3_raw = pb_sync2_r[0];
        2'h1:    line3_raw = pb_sync2_r[1];
        2'h2:    line3_raw = pb_sync2_r[2];
        // code 11 routes no pin to line 3
        default: line3_raw = 1'b0;
    endcase
    case (pinsel_r[5:4])
        2'h0:    line2_raw = pb_sync2_r[3];
        2'h1:    line2_raw = pb_sync2_r[4] & ~in_halt;
        2'h2:    line2_raw = pb_sync2_r[5];
        default: line2_raw = pb_sync2_r[6];
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        ext_irq_lines <= 4'h0;
    end else begin
        ext_irq_lines <= {line3_raw, line2_raw,
                          pa_sync2_r[{1'b1, pinsel_r[3:2]}],
                          pa_sync2_r[{1'b0, pinsel_r[1:0]}]};
    end
end

// ==========================================================
// mode sequencer
wire halt_instr;
wire ahalt_sel;
wire ext_wake;
wire halt_wake;
wire pb4_sel;

assign halt_instr = opcode_valid &
                    (opcode == `PMW_HALT_OPCODE);
assign ahalt_sel  = ctrl_r[`PMW_CTRL_LT_TBIE] |
                    (ctrl_r[`PMW_CTRL_AT_OVERFLOW_IRQ_ENABLE] &
                     ~ctrl_r[`PMW_CTRL_AT_CK1] &
                     ctrl_r[`PMW_CTRL_AT_CK0]);
assign pb4_sel    = (pinsel_r[5:4] == 2'h1);
// line 2 may still hold a pb4 level registered before halt entry
assign ext_wake   = ext_irq_lines[3] | ext_irq_lines[1] |
                    ext_irq_lines[0] |
                    (ext_irq_lines[2] & ~pb4_sel);
assign halt_wake  = irq_halt_capable | ext_wake;

always @(posedge aclk) begin
    if (!aresetn) begin
        // a reset that ends a halt or a stabilisation still lets the
        // oscillator settle before the reset vector is fetched
        if (mode_r == `PMW_MODE_HALT || mode_r == `PMW_MODE_AWU ||
            mode_r == `PMW_MODE_AHALT ||
            mode_r == `PMW_MODE_STAB) begin
            mode_r       <= `PMW_MODE_STAB;
            reset_wake_r <= 1'b1;
            stab_cnt_r   <= stab_long_cfg ? `PMW_STAB_LONG :
                                            `PMW_STAB_SHORT;
        end else begin
            mode_r       <= `PMW_MODE_RUN;
            reset_wake_r <= 1'b0;
            stab_cnt_r   <= 13'h0000;
        end
        stab_long_r     <= 1'b0;
        halt_seen_r     <= 1'b0;
        was_ahalt_r     <= 1'b0;
        clear_imask     <= 1'b0;
        wdg_reset_req   <= 1'b0;
        service_irq     <= 1'b0;
        fetch_reset_vec <= 1'b0;
    end else begin
        clear_imask     <= 1'b0;
        wdg_reset_req   <= 1'b0;
        service_irq     <= 1'b0;
        fetch_reset_vec <= 1'b0;
        if (!halt_seen_r) begin
            halt_seen_r <= 1'b1;
            stab_long_r <= stab_long_cfg;
        end
        case (mode_r)
            `PMW_MODE_RUN: begin
                if (wfi_decoded) begin
                    mode_r      <= `PMW_MODE_WAIT;
                    clear_imask <= 1'b1;
                end else if (halt_instr) begin
                    if (ahalt_sel) begin
                        mode_r      <= `PMW_MODE_AHALT;
                        clear_imask <= 1'b1;
                    end else if (ctrl_r[`PMW_CTRL_WDG_EN] &&
                                 !wdg_halt_option) begin
                        wdg_reset_req <= 1'b1;
                    end else begin
                        mode_r <= ctrl_r[`PMW_CTRL_AWU_EN] ?
                                  `PMW_MODE_AWU :
                                  `PMW_MODE_HALT;
                        clear_imask <= 1'b1;
                    end
                end
            end
            `PMW_MODE_WAIT: begin
                // peripherals keep running; cpu clock is gated
                if (irq_pending) begin
                    mode_r      <= `PMW_MODE_RUN;
                    service_irq <= 1'b1;
                end
            end
            `PMW_MODE_HALT, `PMW_MODE_AWU: begin
                // oscillator restarts; count the settling time
                if (halt_wake) begin
                    mode_r       <= `PMW_MODE_STAB;
                    reset_wake_r <= 1'b0;
                    stab_cnt_r   <= stab_long_r ? `PMW_STAB_LONG :
                                                  `PMW_STAB_SHORT;
                end
            end
            `PMW_MODE_AHALT: begin
                // only the timer wake interrupt ends active-halt
                if (irq_ahalt_capable) begin
                    mode_r      <= `PMW_MODE_RUN;
                    service_irq <= 1'b1;
                end
            end
            `PMW_MODE_STAB: begin
                // reset wake fetches the vector, else the irq is served
                if (stab_cnt_r == 13'h0001) begin
                    mode_r          <= `PMW_MODE_RUN;
                    service_irq     <= ~reset_wake_r;
                    fetch_reset_vec <= reset_wake_r;
                end
                stab_cnt_r <= stab_cnt_r - 13'h0001;
            end
            default: mode_r <= `PMW_MODE_RUN;
        endcase
        was_ahalt_r <= (mode_r == `PMW_MODE_AHALT);
    end
end

// mode code seen by the cpu side and the status register
always @* begin
    mode_out = mode_r;
end

// ==========================================================
// clock gating and slow divider
always @(posedge aclk) begin
    if (!aresetn) begin
        div_cnt_r    <= 5'h00;
        clk_div_tick <= 1'b1;
    end else begin
        // divider runs free so slow ticks stay evenly spaced
        div_cnt_r    <= div_cnt_r + 5'h01;
        clk_div_tick <= ~ctrl_r[`PMW_CTRL_SLOW] |
                        (div_cnt_r == 5'h1f);
    end
end

// ==========================================================
// clock enables per mode
// the oscillator keeps running through stabilisation
always @* begin
    cpu_clk_en    = (mode_r == `PMW_MODE_RUN);
    periph_clk_en = (mode_r == `PMW_MODE_RUN) |
                    (mode_r == `PMW_MODE_WAIT);
    osc_run       = (mode_r != `PMW_MODE_HALT) &
                    (mode_r != `PMW_MODE_AWU);
    timer_clk_en  = periph_clk_en |
                    (mode_r == `PMW_MODE_AHALT);
end

endmodule

//--- logic/pmw_map.vh
// Purpose: constants for the power-mode and wake-up controller
// Assumes: 32-bit AXI4-Lite register slave, 50 MHz aclk
// Notes:   offsets are byte addresses
`ifndef PMW_MAP_VH
`define PMW_MAP_VH

// ==========================================================
// register offsets
`define PMW_OFF_PINSEL     4'h0
`define PMW_OFF_CTRL       4'h4
`define PMW_OFF_STATUS     4'h8
`define PMW_OFF_EVENT      4'hc

// ==========================================================
// field positions and reset values
`define PMW_PINSEL_RST     8'h0c
`define PMW_CTRL_SLOW      0
`define PMW_CTRL_AWU_EN    1
`define PMW_CTRL_LT_TBIE   2
`define PMW_CTRL_AT_OVERFLOW_IRQ_ENABLE  3
`define PMW_CTRL_AT_CK0    4
`define PMW_CTRL_AT_CK1    5
`define PMW_CTRL_WDG_EN    6
`define PMW_CTRL_RST       7'h00

// ==========================================================
// mode codes
`define PMW_MODE_RUN       3'h0
`define PMW_MODE_WAIT      3'h1
`define PMW_MODE_HALT      3'h2
`define PMW_MODE_AHALT     3'h3
`define PMW_MODE_AWU       3'h4
`define PMW_MODE_STAB      3'h5

// ==========================================================
// timing
`define PMW_SLOW_DIV       6'd32
`define PMW_STAB_SHORT     13'd256
`define PMW_STAB_LONG      13'd4096
`define PMW_HALT_OPCODE    8'h8e

`endif

//--- sim/pmw_cpu_model.sv
// Purpose: cpu core model issuing halt and wait instructions
// Assumes: the bench calls run_op just after a clock edge
// Notes:   each executed instruction is a one-cycle pulse
`timescale 1ns/10ps
module pmw_cpu_model (
    input  wire       aclk,
    output reg        opcode_valid,
    output reg  [7:0] opcode,
    output reg        wfi_decoded
);
    initial begin
        opcode_valid = 1'h0;
        opcode = 8'h00;
        wfi_decoded = 1'h0;
    end
    // released byte shows its inverse so a stale opcode is never reused
    task run_op(input logic [7:0] op, input logic wait_for_interrupt_instr);
        begin
            @(posedge aclk);
            opcode_valid <= ~wait_for_interrupt_instr;
            opcode <= op;
            wfi_decoded <= wait_for_interrupt_instr;
            @(posedge aclk);
            opcode_valid <= 1'h0;
            wfi_decoded <= 1'h0;
            opcode <= ~op;
        end
    endtask
endmodule

//--- sim/pmw_ctrl_monitor.sv
// Purpose: assertion checker for the power-mode controller
// Assumes: bound to pmw_ctrl, one clock domain
// Notes:   stabilisation length counted in helper logic
`timescale 1ns/10ps
`include "pmw_map.vh"
module pmw_ctrl_mon (
    input wire       aclk,
    input wire       aresetn,
    input wire       irq_pending,
    input wire       irq_ahalt_capable,
    input wire       cpu_clk_en,
    input wire       periph_clk_en,
    input wire       osc_run,
    input wire       timer_clk_en,
    input wire       clear_imask,
    input wire [3:0] ext_irq_lines,
    input wire [2:0] mode_out
);
    reg  [12:0] stab_r;
    wire        in_stab = mode_out == `PMW_MODE_STAB;
    // ====================
    // cycles spent stabilising
    always @(posedge aclk)
        if (!aresetn || !in_stab)
            stab_r <= 13'h0;
        else
            stab_r <= stab_r + 13'h1;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_run_clk;
        mode_out == `PMW_MODE_RUN |-> cpu_clk_en && periph_clk_en && osc_run;
    endproperty
    a_run_clk: assert property (p_run_clk) else $error("run clocks");
    property p_wait_clk;
        mode_out == `PMW_MODE_WAIT |-> !cpu_clk_en && periph_clk_en;
    endproperty
    a_wait_clk: assert property (p_wait_clk) else $error("wait clk");
    property p_halt_clk;
        mode_out == `PMW_MODE_HALT |-> !(osc_run || cpu_clk_en ||
            periph_clk_en || timer_clk_en);
    endproperty
    a_halt_clk: assert property (p_halt_clk) else $error("halt clk");
    property p_ahalt_clk;
        mode_out == `PMW_MODE_AHALT |-> osc_run && timer_clk_en &&
            !cpu_clk_en && !periph_clk_en;
    endproperty
    a_ahalt_clk: assert property (p_ahalt_clk) else $error("ah clk");
    property p_entry_mask;
        $changed(mode_out) && mode_out inside {`PMW_MODE_WAIT,
            `PMW_MODE_HALT, `PMW_MODE_AHALT} |-> clear_imask;
    endproperty
    a_entry_mask: assert property (p_entry_mask) else $error("mask");
    property p_wait_hold;
        mode_out == `PMW_MODE_WAIT && !irq_pending && ext_irq_lines == 4'h0
            |=> mode_out == `PMW_MODE_WAIT;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait end");
    property p_ahalt_wake;
        mode_out == `PMW_MODE_AHALT && irq_ahalt_capable
            |-> ##[1:3] mode_out == `PMW_MODE_RUN;
    endproperty
    a_ahalt_wake: assert property (p_ahalt_wake) else $error("ah wake");
    property p_stab_len;
        $fell(in_stab) |-> stab_r inside {[13'h0fd:13'h102],
            [13'hffd:13'h1002]};
    endproperty
    a_stab_len: assert property (p_stab_len) else $error("stab len");
endmodule
bind pmw_ctrl pmw_ctrl_mon mon (
    .aclk(aclk), .aresetn(aresetn), .irq_pending(irq_pending),
    .irq_ahalt_capable(irq_ahalt_capable), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .osc_run(osc_run),
    .timer_clk_en(timer_clk_en), .clear_imask(clear_imask),
    .ext_irq_lines(ext_irq_lines), .mode_out(mode_out)
);

//--- sim/test_power_mode_wakeup_controller.sv
// Purpose: self-checking bench for the power-mode controller
// Assumes: cpu model drives the instruction inputs
// Notes:   pin-line and halt-mode expectations come from the functions below
`timescale 1ns/10ps
`include "pmw_map.vh"
module test_power_mode_wakeup_controller;
    logic        aclk = 1'h0, aresetn = 1'h0, irq_pending = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0, stab_long_cfg = 1'h0;
    logic        irq_halt_capable = 1'h0, irq_ahalt_capable = 1'h0;
    logic        wdg_halt_option = 1'h0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [3:0]  s_axi_wstrb = 4'hf, ext_irq_lines;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [7:0]  port_a_pins = 8'h0, port_b_pins = 8'h0, opcode;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, opcode_valid, wfi_decoded, cpu_clk_en;
    logic        periph_clk_en, osc_run, timer_clk_en, clk_div_tick;
    logic        clear_imask, wdg_reset_req, fetch_reset_vec, service_irq;
    logic        wdg_seen, srv_seen, imask_seen, fetch_seen;
    logic [2:0]  mode_out;
    int          error_cnt, total_checks, k, n, e, t;
    int          cfg[8] = '{7'h00, 7'h04, 7'h18, 7'h38, 7'h02, 7'h40,
                            7'h40, 7'h44};
    pmw_ctrl DUT (.*);
    pmw_cpu_model cpu (.aclk(aclk), .opcode_valid(opcode_valid),
        .opcode(opcode), .wfi_decoded(wfi_decoded));
    always #10 aclk = ~aclk;
    // ====================
    // pulse catchers, cleared by reset
    always @(posedge aclk)
        if (!aresetn) begin
            {wdg_seen, srv_seen, imask_seen, fetch_seen} <= 4'h0;
        end else begin
            fetch_seen <= fetch_seen | fetch_reset_vec;
            wdg_seen <= wdg_seen | wdg_reset_req;
            srv_seen <= srv_seen | service_irq;
            imask_seen <= imask_seen | clear_imask;
        end
    function automatic logic [3:0] exp_lines(int s, int a, int b);
        exp_lines[3] = (s >> 6 & 3) == 3 ? 1'h0 : b[s >> 6 & 3];
        exp_lines[2] = b[3 + (s >> 4 & 3)];
        exp_lines[1] = a[4 + (s >> 2 & 3)];
        exp_lines[0] = a[s & 3];
    endfunction
    function automatic int exp_halt(int c, int opt);
        if (c[2] || (c[3] && c[4] && !c[5])) return `PMW_MODE_AHALT;
        if (c[6] && !opt) return 7;
        if (c[1]) return `PMW_MODE_AWU;
        return `PMW_MODE_HALT;
    endfunction
    task chk(input string nm, input logic [31:0] seen, ex);
        total_checks++;
        if (seen !== ex) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task complete_run;
        if (error_cnt == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task axw(input logic [3:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        chk("bresp", {s_axi_bvalid, s_axi_bresp}, 3'h4);
        s_axi_bready <= 1'h0;
    endtask
    task axr(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task do_rst;
        @(posedge aclk);
        aresetn <= 1'h0;
        {port_a_pins, port_b_pins} <= 16'h0;
        {irq_pending, irq_halt_capable, irq_ahalt_capable} <= 3'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
    endtask
    task wait_mode(input logic [2:0] m);
        n = 0;
        while (mode_out !== m && n < 5000) begin
            @(posedge aclk);
            n++;
        end
    endtask
    task ticks(input int c);
        t = 0;
        repeat (c) begin
            @(posedge aclk);
            t += clk_div_tick;
        end
    endtask
    initial begin
        #400000;
        error_cnt++;
        complete_run;
    end
    initial begin
        void'($urandom(88660));
        do_rst;
        axr(`PMW_OFF_PINSEL);
        chk("pinsel", d, 32'h0c);
        axr(`PMW_OFF_CTRL);
        chk("ctrl", d, 32'h0);
        axr(`PMW_OFF_STATUS);
        chk("status", d[2:0], `PMW_MODE_RUN);
        axr(`PMW_OFF_EVENT);
        chk("rresp", r, 2'h2);
        repeat (12) begin
            e = $urandom & 8'hff;
            axw(`PMW_OFF_PINSEL, e);
            port_a_pins <= $urandom;
            port_b_pins <= $urandom;
            repeat (6) @(posedge aclk);
            chk("lines", ext_irq_lines,
                exp_lines(e, port_a_pins, port_b_pins));
        end
        for (k = 0; k < 8; k++) begin
            stab_long_cfg <= k == 6;
            do_rst;
            axw(`PMW_OFF_PINSEL, 32'h10);
            axw(`PMW_OFF_CTRL, cfg[k]);
            wdg_halt_option <= k == 6;
            cpu.run_op(`PMW_HALT_OPCODE, 1'h0);
            repeat (3) @(posedge aclk);
            e = exp_halt(cfg[k], k == 6);
            chk("wdg", wdg_seen, e == 7);
            if (e != 7) chk("mode", mode_out, e);
            if (e != 7) chk("imask", imask_seen, 1'h1);
            if (e == 3) begin
                irq_ahalt_capable <= 1'h1;
                wait_mode(`PMW_MODE_RUN);
                chk("ah wake", n < 5, 1'h1);
            end
            if (e == 2 || e == 4) begin
                port_b_pins <= 8'h10;
                repeat (20) @(posedge aclk);
                chk("pb4", mode_out, e);
                if (e == 2) port_a_pins <= 8'h01;
                else irq_halt_capable <= 1'h1;
                wait_mode(`PMW_MODE_STAB);
                wait_mode(`PMW_MODE_RUN);
                t = k == 6 ? 4096 : 256;
                chk("stab", n >= t - 2 && n <= t + 2, 1'h1);
                @(posedge aclk);
                chk("service", srv_seen, 1'h1);
            end
        end
        // reset out of active-halt waits for the oscillator
        do_rst;
        axw(`PMW_OFF_CTRL, 32'h4);
        cpu.run_op(`PMW_HALT_OPCODE, 1'h0);
        repeat (3) @(posedge aclk);
        chk("ah entry", mode_out, `PMW_MODE_AHALT);
        do_rst;
        chk("rst stab", mode_out, `PMW_MODE_STAB);
        wait_mode(`PMW_MODE_RUN);
        chk("rst delay", n >= 254 && n <= 258, 1'h1);
        @(posedge aclk);
        chk("rst vec", {fetch_seen, srv_seen}, 2'h2);
        do_rst;
        axw(`PMW_OFF_CTRL, 32'h1);
        ticks(64);
        chk("slow", t, 2);
        cpu.run_op(8'h00, 1'h1);
        ticks(64);
        chk("slow wait", t, 2);
        chk("wait", mode_out, `PMW_MODE_WAIT);
        chk("wait mask", imask_seen, 1'h1);
        irq_pending <= 1'h1;
        wait_mode(`PMW_MODE_RUN);
        chk("wait wake", n < 5, 1'h1);
        axw(`PMW_OFF_CTRL, 32'h0);
        ticks(32);
        chk("run ticks", t, 32);
        complete_run;
    end
endmodule
